// file: clock_source_and_wait_select_pkg.sv
// Package: register map, field positions and shared types of the clock select block
`default_nettype none
package clock_source_and_wait_select_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses of 32-bit words)
  // ----------------------------------------------------------------
  localparam logic [7:0] irq_enable_index = 8'h04;
  localparam logic [7:0] clock_select_index = 8'h05;
  localparam logic [7:0] flag_index = 8'h03;
  localparam logic [7:0] status_index = 8'h08;
  localparam logic [9:0] irq_enable_addr = {irq_enable_index, 2'b00};
  localparam logic [9:0] clock_select_addr = {clock_select_index, 2'b00};
  localparam logic [9:0] flag_addr = {flag_index, 2'b00};
  localparam logic [9:0] status_addr = {status_index, 2'b00};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int tick_irq_enable_pos = 7;
  localparam int synth_lockchange_irq_enable_pos = 4;
  localparam int selfclock_irq_enable_pos = 1;
  localparam int tick_event_flag_pos = 7;
  localparam int synth_lockchange_flag_pos = 4;
  localparam int selfclock_change_flag_pos = 1;
  localparam int synth_source_select_pos = 7;
  localparam int pseudo_halt_select_pos = 6;
  localparam int sysclocks_halt_in_wait_pos = 5;
  localparam int reduced_amplitude_in_wait_pos = 4;
  localparam int synth_halt_in_wait_pos = 3;
  localparam int core_halt_in_wait_pos = 2;
  localparam int tick_halt_in_wait_pos = 1;
  localparam int watchdog_halt_in_wait_pos = 0;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] irq_enable_reset = 8'h00;
  localparam logic [7:0] irq_enable_mask = 8'h92;
  localparam logic [7:0] clock_select_reset = 8'h00;
  localparam logic [7:0] flag_mask = 8'h92;
  localparam logic [1:0] bus_clock_divide = 2'h2;

  // ----------------------------------------------------------------
  // Shared types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        lock;
    logic        track;
    logic        auto_bandwidth;
    logic        self_clock_active;
    logic        tick_expired;
    logic        wait_mode;
    logic        stop_mode;
    logic        special_mode;
  } status_in_type;

  typedef struct packed {
    logic        synth_clock_selected;
    logic        oscillator_enable;
    logic        oscillator_reduced;
    logic        synth_powered;
    logic        force_auto_bandwidth;
    logic        sysclock_run;
    logic        core_clock_run;
    logic        tick_run;
    logic        tick_reinit;
    logic        watchdog_run;
    logic        watchdog_reinit;
  } clock_ctrl_type;

  typedef enum logic [2:0] {
    mode_run  = 3'b001,
    mode_wait = 3'b010,
    mode_stop = 3'b100
  } power_mode_type;

endpackage
`default_nettype wire

// file: clock_select_irq_enable.sv
// Interrupt enable and clock select registers with their clock gating effects
//
// Local design decision: the AHB-Lite slave port.
`default_nettype none

module clock_select_irq_enable (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_b_in,
  // AHB-Lite slave
  input  wire logic                      hsel_in,
  input  wire logic [31:0]               haddr_in,
  input  wire logic [1:0]                htrans_in,
  input  wire logic                      hwrite_in,
  input  wire logic [2:0]                hsize_in,
  input  wire logic [31:0]               hwdata_in,
  input  wire logic                      hready_in,
  output logic      [31:0]               hrdata_out,
  output logic                           hreadyout_out,
  output logic                           hresp_out,
  // Clock sources and generator status
  input  wire logic                      oscillator_clock_in,
  input  wire logic                      synth_clock_in,
  input  wire clock_source_and_wait_select_pkg::status_in_type status_in,
  input  wire logic                      synth_power_on_in,
  // Clock generator controls
  output clock_source_and_wait_select_pkg::clock_ctrl_type     ctrl_out,
  output logic                           bus_clock_enable_out,
  output logic                           irq_out
);
  import clock_source_and_wait_select_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]     clock_event_irq_enable;
  logic [7:0]     clock_source_and_wait_select;
  logic [7:0]     flags;
  logic           sel_synth;
  logic [5:0]     sel_free;
  logic           sel_watchdog;
  logic           tick_flag;
  logic           lock_flag;
  logic           scm_flag;
  logic           watchdog_bit_written;
  logic           wr_pending;
  logic [9:0]     wr_addr;
  logic           lock_prev;
  logic           scm_prev;
  logic           wait_prev;
  logic           stop_prev;
  logic           div_phase;
  logic [2:0]     lock_sync;
  logic [2:0]     scm_sync;
  logic [2:0]     osc_sync;
  logic [2:0]     synth_sync;
  logic           lock_now;
  logic           scm_now;
  logic           osc_now;
  logic           synth_now;
  logic           osc_prev;
  logic           synth_prev;
  logic           wr_irq;
  logic           wr_sel;
  logic           wr_flag;
  logic           synth_allowed;
  logic           synth_auto_clear;
  logic           wait_entry;
  logic           src_rise;
  power_mode_type mode;

  // Synchronised level agreed by the last two stages
  function automatic logic agreed(input logic [2:0] s, input logic held);
    agreed = (s[1] == s[2]) ? s[2] : held;
  endfunction

  // Wait mode combined with one halt-in-wait select bit
  function automatic logic halted_in_wait(input power_mode_type m, input logic sel_bit);
    halted_in_wait = (m == mode_wait) && sel_bit;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  // Capture address phase of writes; reads are answered straight from the address phase
  // Only one transfer is ever open, so a single captured address is enough
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_pending <= 1'b0;
      wr_addr <= 10'h000;
    end else if (hready_in) begin
      wr_pending <= hsel_in && htrans_in[1] && hwrite_in;
      wr_addr <= haddr_in[9:0];
    end
  end

  assign wr_irq = wr_pending && (wr_addr == irq_enable_addr);
  assign wr_sel = wr_pending && (wr_addr == clock_select_addr);
  assign wr_flag = wr_pending && (wr_addr == flag_addr);

  // Read data registered at address phase; unmapped reads return zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
      case (haddr_in[9:0])
        irq_enable_addr:   hrdata_out <= {24'h000000, clock_event_irq_enable};
        clock_select_addr: hrdata_out <= {24'h000000, clock_source_and_wait_select};
        flag_addr:         hrdata_out <= {24'h000000, flags};
        status_addr:       hrdata_out <= {28'h0000000, lock_now, scm_now, mode == mode_wait,
                                          mode == mode_stop};
        default:           hrdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin inputs: three-stage synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_sync <= 3'h0;
      scm_sync <= 3'h0;
      osc_sync <= 3'h0;
      synth_sync <= 3'h0;
    end else begin
      lock_sync <= {lock_sync[1:0], status_in.lock};
      scm_sync <= {scm_sync[1:0], status_in.self_clock_active};
      osc_sync <= {osc_sync[1:0], oscillator_clock_in};
      synth_sync <= {synth_sync[1:0], synth_clock_in};
    end
  end

  // Agreed levels and previous values for change detection
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_now <= 1'b0;
      scm_now <= 1'b0;
      lock_prev <= 1'b0;
      scm_prev <= 1'b0;
    end else begin
      lock_now <= agreed(lock_sync, lock_now);
      scm_now <= agreed(scm_sync, scm_now);
      lock_prev <= lock_now;
      scm_prev <= scm_now;
    end
  end

  // ----------------------------------------------------------------
  // Power mode tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode <= mode_run;
      wait_prev <= 1'b0;
      stop_prev <= 1'b0;
    end else begin
      wait_prev <= status_in.wait_mode;
      stop_prev <= status_in.stop_mode;
      case ({status_in.stop_mode, status_in.wait_mode})
        2'b00:   mode <= mode_run;
        2'b01:   mode <= mode_wait;
        default: mode <= mode_stop;
      endcase
    end
  end

  assign wait_entry = status_in.wait_mode && !wait_prev;

  // ----------------------------------------------------------------
  // Interrupt enable register
  // ----------------------------------------------------------------
  // Writable at any time, unimplemented bits stay zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clock_event_irq_enable <= irq_enable_reset;
    end else if (wr_irq) begin
      clock_event_irq_enable <= hwdata_in[7:0] & irq_enable_mask;
    end
  end

  // ----------------------------------------------------------------
  // Event flags: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  // Tick flag: a clear in the expiry cycle would lose an event, so set wins
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_flag <= 1'b0;
    end else if (status_in.tick_expired) begin
      tick_flag <= 1'b1;
    end else if (wr_flag && hwdata_in[tick_event_flag_pos]) begin
      tick_flag <= 1'b0;
    end
  end

  // Lock-change flag, set on either direction of the agreed lock level
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_flag <= 1'b0;
    end else if (lock_now != lock_prev) begin
      lock_flag <= 1'b1;
    end else if (wr_flag && hwdata_in[synth_lockchange_flag_pos]) begin
      lock_flag <= 1'b0;
    end
  end

  // Self-clock change flag, set on either direction of the agreed level
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scm_flag <= 1'b0;
    end else if (scm_now != scm_prev) begin
      scm_flag <= 1'b1;
    end else if (wr_flag && hwdata_in[selfclock_change_flag_pos]) begin
      scm_flag <= 1'b0;
    end
  end

  // Flag word as software sees it; unused positions read as zero
  assign flags = {tick_flag, 2'b00, lock_flag, 2'b00, scm_flag, 1'b0};

  // Combined request; each source gated by its own enable
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (flags[tick_event_flag_pos] && clock_event_irq_enable[tick_irq_enable_pos])
        || (flags[synth_lockchange_flag_pos]
            && clock_event_irq_enable[synth_lockchange_irq_enable_pos])
        || (flags[selfclock_change_flag_pos]
            && clock_event_irq_enable[selfclock_irq_enable_pos]);
    end
  end

  // ----------------------------------------------------------------
  // Clock select register
  // ----------------------------------------------------------------
  // Only a stable synthesizer may be chosen as system clock source
  assign synth_allowed = status_in.auto_bandwidth ? lock_now : status_in.track;
  assign synth_auto_clear = (scm_now && !scm_prev) || (status_in.stop_mode && !stop_prev)
    || (wait_entry && clock_source_and_wait_select[synth_halt_in_wait_pos]);

  // Source select: automatic clear takes priority over any write
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel_synth <= clock_select_reset[synth_source_select_pos];
    end else if (synth_auto_clear) begin
      sel_synth <= 1'b0;
    end else if (wr_sel) begin
      sel_synth <= hwdata_in[synth_source_select_pos] && synth_allowed;
    end
  end

  // Free bits 6..1, writable at any time
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel_free <= clock_select_reset[6:1];
    end else if (wr_sel) begin
      sel_free <= hwdata_in[6:1];
    end
  end

  // Watchdog halt bit: once after reset in normal modes
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel_watchdog <= clock_select_reset[watchdog_halt_in_wait_pos];
      watchdog_bit_written <= 1'b0;
    end else if (wr_sel && (status_in.special_mode || !watchdog_bit_written)) begin
      sel_watchdog <= hwdata_in[watchdog_halt_in_wait_pos];
      watchdog_bit_written <= 1'b1;
    end
  end

  // Register word; each field has its own process so write rules stay apart
  assign clock_source_and_wait_select = {sel_synth, sel_free, sel_watchdog};

  // ----------------------------------------------------------------
  // Bus clock enable: selected source divided by two
  // ----------------------------------------------------------------
  // Agreed source levels; a level counts only once the last two stages match,
  // so a metastable first stage never produces a false edge
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      osc_now <= 1'b0;
      synth_now <= 1'b0;
      osc_prev <= 1'b0;
      synth_prev <= 1'b0;
    end else begin
      osc_now <= agreed(osc_sync, osc_now);
      synth_now <= agreed(synth_sync, synth_now);
      osc_prev <= osc_now;
      synth_prev <= synth_now;
    end
  end

  // Rising edge of the chosen source toggles the divider phase
  // Sources must stay below a quarter of the bus clock or edges are lost
  assign src_rise = clock_source_and_wait_select[synth_source_select_pos]
    ? (synth_now && !synth_prev)
    : (osc_now && !osc_prev);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_phase <= 1'b0;
      bus_clock_enable_out <= 1'b0;
    end else begin
      bus_clock_enable_out <= 1'b0;
      if (src_rise) begin
        div_phase <= ~div_phase;
        bus_clock_enable_out <= div_phase && ctrl_out.sysclock_run;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode-dependent clock controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_out <= '0;
    end else begin
      ctrl_out.synth_clock_selected <= clock_source_and_wait_select[synth_source_select_pos];
      ctrl_out.oscillator_enable <= (mode != mode_stop)
        || clock_source_and_wait_select[pseudo_halt_select_pos];
      ctrl_out.oscillator_reduced <= ((mode == mode_stop)
        && clock_source_and_wait_select[pseudo_halt_select_pos])
        || halted_in_wait(mode,
             clock_source_and_wait_select[reduced_amplitude_in_wait_pos]);
      ctrl_out.synth_powered <= synth_power_on_in
        && !halted_in_wait(mode, clock_source_and_wait_select[synth_halt_in_wait_pos]);
      ctrl_out.force_auto_bandwidth <= clock_source_and_wait_select[synth_halt_in_wait_pos];
      ctrl_out.sysclock_run <= !halted_in_wait(mode,
        clock_source_and_wait_select[sysclocks_halt_in_wait_pos]);
      ctrl_out.core_clock_run <= !halted_in_wait(mode,
        clock_source_and_wait_select[core_halt_in_wait_pos]);
      ctrl_out.tick_run <= !halted_in_wait(mode,
        clock_source_and_wait_select[tick_halt_in_wait_pos]);
      ctrl_out.tick_reinit <= wait_entry
        && clock_source_and_wait_select[tick_halt_in_wait_pos];
      ctrl_out.watchdog_run <= !halted_in_wait(mode,
        clock_source_and_wait_select[watchdog_halt_in_wait_pos]);
      ctrl_out.watchdog_reinit <= wait_entry
        && clock_source_and_wait_select[watchdog_halt_in_wait_pos];
    end
  end

endmodule
`default_nettype wire

// file: clock_select_irq_enable_asserts.sv
// Checker of the clock select block's port behaviour
`default_nettype none
module clock_select_irq_enable_asserts (
  // Clock and reset
  input wire logic                       clk_in,
  input wire logic                       rst_b_in,
  // Observed outputs and status
  input wire logic [31:0]                hrdata_out,
  input wire logic                       hreadyout_out,
  input wire logic                       hresp_out,
  input wire clock_source_and_wait_select_pkg::status_in_type  status_in,
  input wire clock_source_and_wait_select_pkg::clock_ctrl_type ctrl_out,
  input wire logic                       bus_clock_enable_out
);
  import clock_source_and_wait_select_pkg::*;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Three awake cycles let the registered controls settle first
  sequence awake_steady;
    (!status_in.wait_mode && !status_in.stop_mode) [*3];
  endsequence
  // A reinit strobe is one cycle wide and follows a sampled wait
  sequence reinit_after_wait;
    $past(status_in.wait_mode) ##1 1'b1;
  endsequence
  a_bus_always_ready: assert property (hreadyout_out)
    else $error("bus slave inserted a wait state");
  a_bus_resp_okay: assert property (!hresp_out)
    else $error("bus slave gave an error response");
  a_read_upper_zero: assert property (hrdata_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_stop_clears_synth: assert property (
    $rose(status_in.stop_mode) |-> ##[1:3] !ctrl_out.synth_clock_selected)
    else $error("synth source still selected after stop entry");
  a_selfclock_clears: assert property (
    $rose(status_in.self_clock_active) |-> ##[1:8] !ctrl_out.synth_clock_selected)
    else $error("synth source still selected after self clock entry");
  a_tick_reinit_wait: assert property (
    ctrl_out.tick_reinit |-> reinit_after_wait ##0 !ctrl_out.tick_reinit)
    else $error("tick reinit outside wait entry or too long");
  a_wdog_reinit_wait: assert property (
    ctrl_out.watchdog_reinit |-> reinit_after_wait ##0 !ctrl_out.watchdog_reinit)
    else $error("watchdog reinit outside wait entry or too long");
  a_core_runs_awake: assert property (
    awake_steady |-> ctrl_out.core_clock_run && ctrl_out.sysclock_run)
    else $error("core or system clock stopped while awake");
  a_timers_run_awake: assert property (
    awake_steady |-> ctrl_out.tick_run && ctrl_out.watchdog_run)
    else $error("tick or watchdog stopped while awake");
  a_bus_enable_pulse: assert property (bus_clock_enable_out |=> !bus_clock_enable_out)
    else $error("bus clock enable wider than one cycle");
endmodule
bind clock_select_irq_enable clock_select_irq_enable_asserts i_clock_select_irq_enable_asserts (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .status_in(status_in), .ctrl_out(ctrl_out),
  .bus_clock_enable_out(bus_clock_enable_out));
`default_nettype wire

// file: tb_top.sv
// Testbench of the clock select and interrupt enable block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_source_and_wait_select_pkg::*;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic           clk_in, rst_b_in, hsel, hwrite, osc, synth, synth_on, hreadyout, hresp;
  logic           bus_en, irq;
  logic [1:0]     htrans;
  logic [2:0]     hsize;
  logic [31:0]    haddr, hwdata, hrdata, q;
  logic [7:0]     m;
  status_in_type  st;
  clock_ctrl_type ctrl;
  int             miscompares = 0;
  int             tests_run = 0;
  int             pulses = 0;
  int             p;
  clock_select_irq_enable i_clock_select_irq_enable (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .oscillator_clock_in(osc), .synth_clock_in(synth), .status_in(st),
    .synth_power_on_in(synth_on), .ctrl_out(ctrl), .bus_clock_enable_out(bus_en), .irq_out(irq));
  // Bus clock and two slow source clocks, changing on falling bus clock edges
  always #5 clk_in = ~clk_in;
  always #40 osc = ~osc;
  always #60 synth = ~synth;
  // Count bus clock enable strobes
  always @(posedge clk_in) if (bus_en === 1'b1) pulses <= pulses + 1;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // One single transfer; address phase held until ready, data taken at the last edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, a};
    hwrite <= wr;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input string name);
    bus(1'b0, a, 8'h00);
    chk(name, q, {24'h0, e});
  endtask
  // Raise one event source: tick pulse, lock change or self clock change
  task automatic fire(input int i);
    if (i == 0) begin
      st.tick_expired <= 1'b1;
      cyc(1);
      st.tick_expired <= 1'b0;
    end else
      st <= st ^ (i == 1 ? 8'h80 : 8'h10);
  endtask
  // Enter wait with a given select value and compare every control
  task automatic wait_case(input logic [7:0] sel, input logic [10:0] exp);
    wr(clock_select_addr, sel);
    st <= st | 8'h04;
    cyc(4);
    chk("wait controls", {21'h0, ctrl}, {21'h0, exp});
    st <= st & 8'hfb;
    cyc(4);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Slow limit is far above the roughly six hundred and forty cycles needed
  initial begin
    cyc(20000);
    miscompares++;
    stop_test();
  end
  initial begin
    {clk_in, rst_b_in, hsel, hwrite, osc, synth, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    synth_on = 1'b1;
    st = 8'h20;
    cyc(20);
    rst_b_in <= 1'b1;
    cyc(1);
    rd(irq_enable_addr, 8'h00, "irq enable reset");
    rd(clock_select_addr, 8'h00, "select reset");
    wr(irq_enable_addr, 8'hff);
    rd(irq_enable_addr, 8'h92, "irq enable");
    wr(10'h30, 8'hff);
    rd(10'h30, 8'h00, "unmapped");
    wr(clock_select_addr, 8'h7f);
    rd(clock_select_addr, 8'h7f, "select all");
    chk("auto forced", {31'h0, ctrl.force_auto_bandwidth}, 32'h1);
    wr(clock_select_addr, 8'h00);
    rd(clock_select_addr, 8'h01, "watchdog once");
    chk("auto free", {31'h0, ctrl.force_auto_bandwidth}, 32'h0);
    wr(clock_select_addr, 8'h81);
    rd(clock_select_addr, 8'h01, "select unlocked");
    st <= 8'ha0;
    cyc(6);
    wr(clock_select_addr, 8'h81);
    rd(clock_select_addr, 8'h81, "select locked");
    chk("synth selected", {31'h0, ctrl.synth_clock_selected}, 32'h1);
    wr(clock_select_addr, 8'h01);
    st <= 8'h80;
    wr(clock_select_addr, 8'h81);
    rd(clock_select_addr, 8'h01, "select untracked");
    st <= 8'hc0;
    wr(clock_select_addr, 8'h81);
    rd(clock_select_addr, 8'h81, "select tracked");
    st <= 8'hc2;
    cyc(3);
    rd(clock_select_addr, 8'h01, "stop clears");
    st <= 8'hc0;
    wr(clock_select_addr, 8'h89);
    st <= 8'hc4;
    cyc(3);
    st <= 8'hc0;
    cyc(3);
    rd(clock_select_addr, 8'h09, "wait clears");
    wr(clock_select_addr, 8'h81);
    st <= 8'hd0;
    cyc(8);
    rd(clock_select_addr, 8'h01, "scm clears");
    st <= 8'hc0;
    for (int i = 0; i < 2; i++) begin
      wr(clock_select_addr, i ? 8'h41 : 8'h01);
      st <= 8'hc2;
      cyc(4);
      chk("stop osc", {30'h0, ctrl.oscillator_enable, ctrl.oscillator_reduced}, i ? 3 : 0);
      st <= 8'hc0;
      cyc(4);
    end
    wait_case(8'h3f, 11'h340);
    wait_case(8'h01, 11'h2b8);
    st <= 8'hc1;
    wr(clock_select_addr, 8'h00);
    rd(clock_select_addr, 8'h00, "watchdog special");
    wait_case(8'h00, 11'h2ba);
    st <= 8'hc0;
    cyc(8);
    wr(flag_addr, 8'h92);
    rd(flag_addr, 8'h00, "flags clear");
    // Each source masked first, then enabled, then cleared by software
    for (int i = 0; i < 3; i++) begin
      m = i == 0 ? 8'h80 : (i == 1 ? 8'h10 : 8'h02);
      wr(irq_enable_addr, 8'h92 & ~m);
      fire(i);
      cyc(8);
      chk("masked irq", {31'h0, irq}, 32'h0);
      rd(flag_addr, m, "event flag");
      wr(flag_addr, 8'h00);
      wr(irq_enable_addr, m);
      cyc(2);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(flag_addr, m);
      cyc(2);
      chk("irq cleared", {31'h0, irq}, 32'h0);
    end
    p = pulses;
    cyc(160);
    chk("osc strobes", {31'h0, (pulses - p) inside {[9:11]}}, 32'h1);
    st <= 8'ha0;
    cyc(6);
    wr(clock_select_addr, 8'h80);
    p = pulses;
    cyc(240);
    chk("synth strobes", {31'h0, (pulses - p) inside {[9:11]}}, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
